// ==== vsd_consts.svh ====
// constants for the serial display byte decoder
`ifndef VSD_CONSTS_SVH
`define VSD_CONSTS_SVH

// ==================================================
// timing
`define VSD_CLK_NS 25
`define VSD_TICK_NS 1000
`define VSD_TICK_CYC ((`VSD_TICK_NS + `VSD_CLK_NS - 1) / `VSD_CLK_NS)
`define VSD_PHASE_LAST 5'h1E
`define VSD_BIT_LAST 3'h7

// ==================================================
// byte decoding
`define VSD_OP_PTR 4'hA
`define VSD_OP_CNT 4'hC
`define VSD_OP_DUTY 3'h7
`define VSD_CODE_COMMA 6'h2C
`define VSD_CODE_DOT 6'h2E

// ==================================================
// reset values
`define VSD_PTR_RST 4'hF
`define VSD_CNT_RST 4'h0
`define VSD_DUTY_RST 5'h00
`define VSD_EN_RST 1'b1

// ==================================================
// register map (word indices compared with paddr_i[7:2]; VSD_A_BUF_HI is compared with paddr_i[7:4])
`define VSD_A_CTRL 6'h00
`define VSD_A_INJECT 6'h01
`define VSD_A_STATUS 6'h02
`define VSD_A_BUF_HI 4'h1

`endif

// ==== vsd_pkg.sv ====
// types shared by the serial display byte decoder
package vsd_pkg;

    typedef struct packed {
        logic vld;
        logic [7:0] data;
    } vsd_rx_t;

    typedef struct packed {
        logic dp;
        logic comma;
        logic [5:0] glyph;
    } vsd_cell_t;

endpackage : vsd_pkg

// ==== vsd_shift_rx.sv ====
// serial clock/data receiver: synchronises pins and assembles bytes
`timescale 1ns/1ps
`include "vsd_consts.svh"

module vsd_shift_rx import vsd_pkg::*; (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // control from the decoder
    input wire logic clr_i,
    input wire logic en_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic sdata_i,
    // assembled byte
    output vsd_rx_t rx_o
);

    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic data_s1_q, data_s2_q;
    logic [6:0] sh_q, sh_d;
    logic [2:0] cnt_q, cnt_d;
    vsd_rx_t rx_q, rx_d;
    logic fall;

    assign fall = sclk_s3_q & ~sclk_s2_q;
    assign rx_o = rx_q;

    // ==================================================
    // shifting
    always_comb begin
        sh_d = sh_q;
        cnt_d = cnt_q;
        rx_d = '0;
        if (clr_i || !en_i) begin
            cnt_d = 3'h0;
        end else if (fall) begin
            // msb arrives first, so older bits move up
            sh_d = {sh_q[5:0], data_s2_q};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == `VSD_BIT_LAST) begin
                rx_d.vld = 1'b1;
                rx_d.data = {sh_q, data_s2_q};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_s3_q <= 1'b1;
            data_s1_q <= 1'b0;
            data_s2_q <= 1'b0;
            sh_q <= '0;
            cnt_q <= 3'h0;
            rx_q <= '0;
        end else begin
            sclk_s1_q <= sclk_i;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            data_s1_q <= sdata_i;
            data_s2_q <= data_s1_q;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_byte_after_eight: assert property (
        en_i && !clr_i && fall && cnt_q == 3'h7
        |=> rx_q.vld && rx_q.data[0] == $past(data_s2_q))
        else $error("byte not delivered on eighth falling edge");

endmodule : vsd_shift_rx

// ==== vsd_decoder.sv ====
// serial display byte decoder with apb status/control and digit scan
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "vsd_consts.svh"

module vsd_decoder import vsd_pkg::*; (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // display module pins
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic disp_rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // decoded state
    output logic [3:0] ptr_o,
    output logic [3:0] digit_cnt_o,
    output logic [4:0] duty_o,
    // digit scan
    output logic [3:0] grid_sel_o,
    output logic grid_on_o,
    output vsd_cell_t seg_cell_o
);

    // ==================================================
    // reset pin synchroniser and receiver
    logic drst_s1_q, drst_s2_q;
    logic soft_rst;
    logic en_q, en_d;
    vsd_rx_t rx;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drst_s1_q <= 1'b0;
            drst_s2_q <= 1'b0;
        end else begin
            drst_s1_q <= disp_rst_n_i;
            drst_s2_q <= drst_s1_q;
        end
    end

    // the host holds the pin low long enough to cross the synchroniser
    assign soft_rst = !drst_s2_q;

    vsd_shift_rx u_rx (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .clr_i(soft_rst),
        .en_i(en_q),
        .sclk_i(sclk_i),
        .sdata_i(sdata_i),
        .rx_o(rx)
    );

    // ==================================================
    // apb slave: one setup, one access cycle, no waits
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [31:0] rdata;
    logic hit, setup, wr;
    logic inj_pend_q, inj_pend_d;
    logic [7:0] inj_byte_q, inj_byte_d;
    logic [3:0] ptr_q, ptr_d;
    logic [3:0] cnt_q, cnt_d;
    logic [4:0] duty_q, duty_d;
    vsd_cell_t [15:0] buf_q;
    vsd_cell_t [15:0] buf_d;
    logic [5:0] widx;

    assign setup = psel_i && !penable_i;
    assign widx = paddr_i[7:2];
    assign wr = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;

    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        if (widx == `VSD_A_CTRL) begin
            rdata[0] = en_q;
        end else if (widx == `VSD_A_INJECT) begin
            rdata[7:0] = inj_byte_q;
        end else if (widx == `VSD_A_STATUS) begin
            rdata = {18'h0, inj_pend_q, duty_q, cnt_q, ptr_q};
        end else if (widx[5:2] == `VSD_A_BUF_HI) begin
            rdata = {buf_q[{widx[1:0], 2'h3}], buf_q[{widx[1:0], 2'h2}],
                     buf_q[{widx[1:0], 2'h1}], buf_q[{widx[1:0], 2'h0}]};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        pready_d = setup;
        pslverr_d = setup && !hit;
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = pwrite_i ? 32'h0000_0000 : rdata;
        end
        en_d = en_q;
        if (wr && widx == `VSD_A_CTRL) begin
            en_d = pwdata_i[0];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            en_q <= `VSD_EN_RST;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            en_q <= en_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // ==================================================
    // byte decoder
    logic in_vld;
    logic [7:0] in_byte;
    logic [3:0] nxt_ptr;

    // a serial byte wins; an injected byte waits one cycle
    assign in_vld = rx.vld || inj_pend_q;
    assign in_byte = rx.vld ? rx.data : inj_byte_q;
    assign nxt_ptr = ptr_q + 4'h1;

    always_comb begin
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        duty_d = duty_q;
        buf_d = buf_q;
        inj_pend_d = inj_pend_q && rx.vld;
        inj_byte_d = inj_byte_q;
        if (wr && widx == `VSD_A_INJECT) begin
            inj_pend_d = 1'b1;
            inj_byte_d = pwdata_i[7:0];
        end
        if (soft_rst) begin
            duty_d = `VSD_DUTY_RST;
            cnt_d = `VSD_CNT_RST;
            ptr_d = `VSD_PTR_RST;
        end else if (in_vld && in_byte[7]) begin
            if (in_byte[7:5] == `VSD_OP_DUTY) begin
                duty_d = in_byte[4:0];
            end else if (in_byte[7:4] == `VSD_OP_PTR) begin
                ptr_d = in_byte[3:0];
            end else if (in_byte[7:4] == `VSD_OP_CNT) begin
                cnt_d = in_byte[3:0];
            end
            // other control codes fall through unchanged
        end else if (in_vld) begin
            // bit 6 is don't care
            if (in_byte[5:0] == `VSD_CODE_DOT) begin
                buf_d[ptr_q + 4'h1].dp = 1'b1;
            end else if (in_byte[5:0] == `VSD_CODE_COMMA) begin
                buf_d[ptr_q + 4'h1].comma = 1'b1;
            end else begin
                ptr_d = nxt_ptr;
                // slot index is pointer plus one: F is position 1
                buf_d[nxt_ptr + 4'h1] = '{1'b0, 1'b0, in_byte[5:0]};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_q <= `VSD_PTR_RST;
            cnt_q <= `VSD_CNT_RST;
            duty_q <= `VSD_DUTY_RST;
            buf_q <= '0;
            inj_pend_q <= 1'b0;
            inj_byte_q <= 8'h00;
        end else begin
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            duty_q <= duty_d;
            buf_q <= buf_d;
            inj_pend_q <= inj_pend_d;
            inj_byte_q <= inj_byte_d;
        end
    end

    assign ptr_o = ptr_q;
    assign digit_cnt_o = cnt_q;
    assign duty_o = duty_q;

    // ==================================================
    // digit scan: 31 on-time steps per digit slot
    logic [5:0] tick_q, tick_d;
    logic [4:0] phase_q, phase_d;
    logic [3:0] dig_q, dig_d;
    logic [3:0] last_dig;
    logic grid_on_q, grid_on_d;
    vsd_cell_t cell_q, cell_d;
    logic tick;

    assign tick = (tick_q == 6'(`VSD_TICK_CYC - 1));
    // count 0 encodes sixteen positions
    assign last_dig = cnt_q - 4'h1;

    always_comb begin
        tick_d = tick ? 6'h00 : tick_q + 6'h01;
        phase_d = phase_q;
        dig_d = dig_q;
        if (tick) begin
            if (phase_q == `VSD_PHASE_LAST) begin
                phase_d = 5'h00;
                dig_d = (dig_q == last_dig) ? 4'h0 : dig_q + 4'h1;
            end else begin
                phase_d = phase_q + 5'h01;
            end
        end
        if (dig_d > last_dig) begin
            dig_d = 4'h0;
        end
        // duty 31 covers every phase; duty 0 covers none
        grid_on_d = (phase_q < duty_q);
        cell_d = buf_q[dig_q];
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_q <= 6'h00;
            phase_q <= 5'h00;
            dig_q <= 4'h0;
            grid_on_q <= 1'b0;
            cell_q <= '0;
        end else begin
            tick_q <= tick_d;
            phase_q <= phase_d;
            dig_q <= dig_d;
            grid_on_q <= grid_on_d;
            cell_q <= cell_d;
        end
    end

    assign grid_sel_o = dig_q;
    assign grid_on_o = grid_on_q;
    assign seg_cell_o = cell_q;

    // ==================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_ctl;
        in_vld && in_byte[7] && !soft_rst;
    endsequence

    sequence s_chr;
        in_vld && !in_byte[7] && !soft_rst;
    endsequence

    a_ctrl_not_stored: assert property (
        s_ctl |=> $stable(buf_q))
        else $error("control byte changed the buffer");

    a_ptr_load_val: assert property (
        s_ctl ##0 in_byte[7:4] == 4'hA |=> ptr_q == $past(in_byte[3:0]))
        else $error("pointer not loaded");

    a_cnt_load_val: assert property (
        s_ctl ##0 in_byte[7:4] == 4'hC |=> cnt_q == $past(in_byte[3:0]))
        else $error("digit counter not loaded");

    a_duty_load_val: assert property (
        s_ctl ##0 in_byte[7:5] == 3'h7 |=> duty_q == $past(in_byte[4:0]))
        else $error("duty not loaded");

    a_undef_ignored: assert property (
        s_ctl ##0 (in_byte[7:4] == 4'h8 || in_byte[7:4] == 4'h9
                   || in_byte[7:4] == 4'hB || in_byte[7:4] == 4'hD)
        |=> $stable(ptr_q) && $stable(cnt_q) && $stable(duty_q))
        else $error("undefined control byte changed state");

    a_char_advance: assert property (
        s_chr ##0 in_byte[5:0] != 6'h2C && in_byte[5:0] != 6'h2E
        |=> ptr_q == $past(ptr_q) + 4'h1
            && buf_q[ptr_q + 4'h1].glyph == $past(in_byte[5:0]))
        else $error("character not stored after advance");

    a_punct_hold: assert property (
        s_chr ##0 (in_byte[5:0] == 6'h2C || in_byte[5:0] == 6'h2E)
        |=> $stable(ptr_q))
        else $error("punctuation advanced the pointer");

    a_ptr_wrap: assert property (
        s_chr ##0 ptr_q == 4'hE ##0 in_byte[5:0] != 6'h2C
        ##0 in_byte[5:0] != 6'h2E |=> ptr_q == 4'hF)
        else $error("pointer did not wrap to position one");

    a_blank_dark: assert property (
        duty_q == 5'h00 ##1 duty_q == 5'h00 |-> !grid_on_q)
        else $error("display lit with zero duty");

    a_full_on: assert property (
        duty_q == 5'h1F ##1 duty_q == 5'h1F |-> grid_on_q)
        else $error("display dark with full duty");

    a_pin_defaults: assert property (
        soft_rst |=> duty_q == 5'h00 && cnt_q == 4'h0 && ptr_q == 4'hF)
        else $error("reset pin did not restore defaults");

endmodule : vsd_decoder

// ==== vsd_host_model.sv ====
// host-side model for the display's serial clock, data and reset pins
`timescale 1ns/1ps

module vsd_host_model (
    // clock
    input wire logic mclk_i,
    // display pins
    output logic sclk_o,
    output logic sdata_o,
    output logic rst_n_o
);
    // ==================================================
    // pins
    // serial clock idles high and moves only inside a byte
    initial begin
        sclk_o = 1'b1;
        sdata_o = 1'b0;
        rst_n_o = 1'b1;
    end

    // ==================================================
    // byte and reset tasks
    // four mclk per half gives the 200 ns serial period
    task send(input logic [7:0] b);
        @(posedge mclk_i);
        for (int i = 7; i >= 0; i--) begin
            sclk_o <= 1'b1;
            sdata_o <= b[i];
            repeat (4) @(posedge mclk_i);
            sclk_o <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
        sclk_o <= 1'b1;
        // released data line must not keep showing the last bit
        sdata_o <= ~b[0];
    endtask : send

    task pin_reset;
        @(posedge mclk_i);
        rst_n_o <= 1'b0;
        repeat (4000) @(posedge mclk_i);
        rst_n_o <= 1'b1;
    endtask : pin_reset
endmodule : vsd_host_model

// ==== tb_vsd_decoder.sv ====
// self-checking bench for the serial display byte decoder
`timescale 1ns/1ps

module tb_vsd_decoder import vsd_pkg::*; ;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sclk, sdata, drst_n;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, grid_on_o;
    logic [3:0] ptr_o, digit_cnt_o, grid_sel_o, mx;
    logic [4:0] duty_o;
    vsd_cell_t seg_cell_o;
    logic [31:0] rd;
    logic er;
    logic [3:0] sel;
    logic [7:0] cel;
    logic [7:0] undef_b [4] = '{8'h85, 8'h9A, 8'hB3, 8'hD7};
    int err_count, num_checks, cyc, on;

    always #12.5 mclk_i = ~mclk_i;

    vsd_host_model u_vsd_host_model (.mclk_i(mclk_i), .sclk_o(sclk),
        .sdata_o(sdata), .rst_n_o(drst_n));

    vsd_decoder u_vsd_decoder (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .sclk_i(sclk), .sdata_i(sdata), .disp_rst_n_i(drst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ptr_o(ptr_o),
        .digit_cnt_o(digit_cnt_o), .duty_o(duty_o),
        .grid_sel_o(grid_sel_o), .grid_on_o(grid_on_o),
        .seg_cell_o(seg_cell_o));

    // ==================================================
    // tasks
    task final_report;
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task tx(input logic [7:0] b);
        u_vsd_host_model.send(b);
        repeat (10) @(posedge mclk_i);
    endtask : tx

    task st(input logic [3:0] p, input logic [3:0] c, input logic [4:0] d);
        chk({19'h0, duty_o, digit_cnt_o, ptr_o}, {19'h0, d, c, p});
    endtask : st

    task bufchk(input int s, input logic [7:0] e);
        apb(1'b0, 8'h10 + 8'(4 * (s / 4)), 32'h0);
        chk(32'(rd[8 * (s % 4) +: 8]), 32'(e));
    endtask : bufchk

    // grid on-cycles and highest slot over n cycles
    task scan(input int n);
        on = 0;
        mx = 4'h0;
        sel = 4'hF;
        repeat (n) begin
            @(posedge mclk_i);
            if (grid_on_o === 1'b1) on++;
            if (grid_sel_o > mx) mx = grid_sel_o;
            // the cell output lags the slot index by one cycle
            if (sel == 4'h1) cel = seg_cell_o;
            sel = grid_sel_o;
        end
    endtask : scan

    // ==================================================
    // hang guard
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end

    // ==================================================
    // main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        st(4'hF, 4'h0, 5'h00);
        // digit count goes first, while slot 0 is still scanned
        tx(8'hC2);
        st(4'hF, 4'h2, 5'h00);
        tx(8'hFF);
        st(4'hF, 4'h2, 5'h1F);
        scan(2480);
        chk(on, 2480);
        chk(32'(mx), 32'h1);
        tx(8'hF0);
        scan(2480);
        chk(on, 1280);
        tx(8'hE0);
        scan(2480);
        chk(on, 0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000002F);
        for (int i = 0; i < 16; i++) begin
            tx(8'hA0 | 8'(i));
            chk(32'(ptr_o), 32'(i));
        end
        foreach (undef_b[i]) begin
            tx(undef_b[i]);
            st(4'hF, 4'h2, 5'h00);
        end
        bufchk(0, 8'h00);
        tx(8'hAF);
        tx(8'h41);
        st(4'h0, 4'h2, 5'h00);
        bufchk(1, 8'h01);
        tx(8'h2E);
        chk(32'(ptr_o), 32'h0);
        bufchk(1, 8'h81);
        tx(8'h2C);
        bufchk(1, 8'hC1);
        tx(8'hAA);
        tx(8'h05);
        bufchk(12, 8'h05);
        tx(8'hAD);
        tx(8'h1A);
        bufchk(15, 8'h1A);
        tx(8'hAE);
        tx(8'h3F);
        chk(32'(ptr_o), 32'hF);
        bufchk(0, 8'h3F);
        scan(2480);
        chk(32'(cel), 32'hC1);
        apb(1'b1, 8'h04, 32'h000000E5);
        repeat (10) @(posedge mclk_i);
        chk({31'h0, er}, 32'h0);
        st(4'hF, 4'h2, 5'h05);
        apb(1'b1, 8'h00, 32'h0);
        tx(8'hE9);
        chk(32'(duty_o), 32'h05);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        u_vsd_host_model.pin_reset();
        repeat (5) @(posedge mclk_i);
        st(4'hF, 4'h0, 5'h00);
        bufchk(0, 8'h3F);
        final_report();
    end
endmodule : tb_vsd_decoder
